/* dhi_edge.sv */
// Purpose : Package of shared constants for the display host front end, and a
//           small edge detector used on each strobe and serial clock pin.
// Assumes : All pins are synchronous to clk_sys_i.
// Notes   : The strap encodings are a local choice; boards must strap to match.
`timescale 1ns/1ps
`default_nettype none

package dhi_pkg;
  typedef enum logic [1:0] {
    DHI_MODE_PAR_E,
    DHI_MODE_PAR_RW,
    DHI_MODE_SERIAL,
    DHI_MODE_TWO_WIRE
  } dhi_mode_t;

  // ----------------------------------------------------------------------
  // Strap codes {proto_strap_2, proto_strap_1, proto_strap_0}
  // ----------------------------------------------------------------------
  localparam logic [2:0] STRAP_PAR_E    = 3'h4;
  localparam logic [2:0] STRAP_PAR_RW   = 3'h6;
  localparam logic [2:0] STRAP_TWO_WIRE = 3'h2;
  localparam logic [2:0] STRAP_RESET    = 3'h0;

  localparam int         SCLK_BIT       = 0;
  localparam int         SERIAL_DATA_IN_BIT       = 1;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam logic [2:0] BIT_STEP       = 3'h1;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
endpackage

module dhi_edge #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev;

  // Idle level at reset avoids a false edge on the first cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      prev <= IDLE_LEVEL;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;
  assign fall_o = ~level_i & prev;
endmodule

`default_nettype wire

/* dhi_front_end.sv */
// Purpose : Host bus front end of a display controller: decodes chip select,
//           pin reset, data/command select and the strobes of two parallel
//           styles, a serial shift input and the two-wire address bit.
// Assumes : Pins are synchronous to clk_sys_i; straps are static.
// Notes   : The two-wire protocol engine itself sits elsewhere.
//
// How it works
// - Low pin reset blocks transfers, resamples straps and raises chip_init_o
// - Transfers count only while chip select low
// - Parallel byte: data if selector high, else command
// - Serial byte: data if selector high, else command
// - Two-wire mode: selector pin is address bit
// - Enable-strobe style: enable rising starts transfer
// - Separate-strobe style: read strobe falling drives bus
// - Separate-strobe style: write strobe falling writes
// - Serial: line one data, line zero clock
`timescale 1ns/1ps
`default_nettype none

module dhi_front_end (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       reset_n_in_i,
  input  wire logic       cs_n_i,
  input  wire logic       dc_sel_i,
  input  wire logic       rw_sel_i,
  input  wire logic       en_rd_i,
  input  wire logic       proto_strap_0_i,
  input  wire logic       proto_strap_1_i,
  input  wire logic       proto_strap_2_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic      [7:0] data_oe_n_o,
  input  wire logic [7:0] rd_data_i,
  output logic            read_req_o,
  output logic      [7:0] byte_o,
  output logic            byte_valid_o,
  output logic            byte_is_data_o,
  output logic            addr_low_bit_o,
  output logic            chip_init_o,
  output logic      [1:0] mode_o
);
  // ----------------------------------------------------------------------
  // Mode and gating
  // ----------------------------------------------------------------------
  logic             [2:0] strap_q;
  dhi_pkg::dhi_mode_t     mode;
  wire                    init_req = ~reset_n_in_i;
  wire                    cs_act   = ~cs_n_i & ~init_req;
  wire                    serial_data_in = data_i[dhi_pkg::SERIAL_DATA_IN_BIT];
  wire                    sclk_in        = data_i[dhi_pkg::SCLK_BIT];

  // Straps follow the pins while reset is low and freeze at release
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      strap_q <= dhi_pkg::STRAP_RESET;
    end else if (init_req) begin
      strap_q <= {proto_strap_2_i, proto_strap_1_i, proto_strap_0_i};
    end
  end

  assign mode = (strap_q == dhi_pkg::STRAP_PAR_E)    ? dhi_pkg::DHI_MODE_PAR_E :
                (strap_q == dhi_pkg::STRAP_PAR_RW)   ? dhi_pkg::DHI_MODE_PAR_RW :
                (strap_q == dhi_pkg::STRAP_TWO_WIRE) ? dhi_pkg::DHI_MODE_TWO_WIRE :
                                                       dhi_pkg::DHI_MODE_SERIAL;
  assign mode_o = mode;

  // ----------------------------------------------------------------------
  // Strobe edges
  // ----------------------------------------------------------------------
  logic en_rise, en_rd_fall, wr_fall, sclk_rise;

  dhi_edge #(.IDLE_LEVEL(1'b0)) u_edge_en (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .level_i   (en_rd_i),
    .rise_o    (en_rise),
    .fall_o    ()
  );

  // Read strobe is active low, so its idle level is high
  dhi_edge #(.IDLE_LEVEL(1'b1)) u_edge_rd (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .level_i   (en_rd_i),
    .rise_o    (),
    .fall_o    (en_rd_fall)
  );

  dhi_edge #(.IDLE_LEVEL(1'b1)) u_edge_wr (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .level_i   (rw_sel_i),
    .rise_o    (),
    .fall_o    (wr_fall)
  );

  dhi_edge #(.IDLE_LEVEL(1'b0)) u_edge_sclk (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .level_i   (sclk_in),
    .rise_o    (sclk_rise),
    .fall_o    ()
  );

  // ----------------------------------------------------------------------
  // Transfer decode
  // ----------------------------------------------------------------------
  wire mode_e   = (mode == dhi_pkg::DHI_MODE_PAR_E);
  wire mode_rw  = (mode == dhi_pkg::DHI_MODE_PAR_RW);
  wire mode_ser = (mode == dhi_pkg::DHI_MODE_SERIAL);
  wire mode_two = (mode == dhi_pkg::DHI_MODE_TWO_WIRE);

  wire e_start  = mode_e & cs_act & en_rise;
  wire e_write  = e_start & ~rw_sel_i;
  wire e_read   = e_start & rw_sel_i;
  wire rw_read  = mode_rw & cs_act & en_rd_fall;
  wire rw_write = mode_rw & cs_act & wr_fall;
  wire par_take = e_write | rw_write;
  wire rd_take  = e_read | rw_read;

  // Bus is driven only for the strobe's active phase
  wire drive_en = (mode_e & cs_act & rw_sel_i & en_rd_i) |
                  (mode_rw & cs_act & ~en_rd_i);

  logic [2:0] bit_cnt;
  logic [6:0] shift_q;
  wire        ser_take = mode_ser & cs_act & sclk_rise;
  wire        ser_done = ser_take & (bit_cnt == dhi_pkg::BIT_LAST);
  wire [7:0]  ser_byte = {shift_q, serial_data_in};

  wire [7:0]  next_byte  = ser_done ? ser_byte : data_i;
  wire        next_valid = par_take | ser_done;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt <= dhi_pkg::BIT_FIRST;
      shift_q <= 7'h00;
    end else if (!cs_act || !mode_ser) begin
      bit_cnt <= dhi_pkg::BIT_FIRST;
    end else if (ser_take) begin
      bit_cnt <= bit_cnt + dhi_pkg::BIT_STEP;
      shift_q <= {shift_q[5:0], serial_data_in};
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      byte_o         <= dhi_pkg::BYTE_RESET;
      byte_valid_o   <= 1'b0;
      byte_is_data_o <= 1'b0;
      read_req_o     <= 1'b0;
      data_o         <= dhi_pkg::BYTE_RESET;
      data_oe_n_o    <= 8'hFF;
      addr_low_bit_o <= 1'b0;
      chip_init_o    <= 1'b1;
    end else begin
      chip_init_o    <= init_req;
      byte_valid_o   <= next_valid;
      read_req_o     <= rd_take;
      data_oe_n_o    <= {8{~drive_en}};
      addr_low_bit_o <= mode_two & dc_sel_i;
      if (next_valid) begin
        byte_o         <= next_byte;
        byte_is_data_o <= dc_sel_i;
      end
      if (rd_take) begin
        data_o <= rd_data_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_e_read_start;
    mode_e && !cs_n_i && reset_n_in_i && en_rise && rw_sel_i;
  endsequence

  sequence s_drive_begins;
    read_req_o && data_oe_n_o == 8'h00;
  endsequence

  a_init_quiet: assert property (!reset_n_in_i |=> !byte_valid_o && !read_req_o && chip_init_o)
    else $error("activity seen during pin reset");
  a_cs_gate: assert property (cs_n_i |=> !byte_valid_o && !read_req_o && data_oe_n_o == 8'hFF)
    else $error("transfer taken with chip select high");
  a_par_route: assert property (par_take |=> byte_valid_o && byte_is_data_o == $past(dc_sel_i))
    else $error("parallel byte routed wrongly");
  a_par_byte: assert property (par_take |=> byte_o == $past(data_i))
    else $error("parallel byte value wrong");
  a_ser_route: assert property (ser_done |=> byte_valid_o && byte_is_data_o == $past(dc_sel_i))
    else $error("serial byte routed wrongly");
  a_ser_bits: assert property (ser_done |=> byte_o == {$past(shift_q), $past(data_i[1])})
    else $error("serial byte assembled wrongly");
  a_addr_bit: assert property (mode_two && reset_n_in_i |=> addr_low_bit_o == $past(dc_sel_i))
    else $error("address bit does not follow selector");
  a_e_read: assert property (s_e_read_start |=> s_drive_begins)
    else $error("enable rise did not start read");
  a_rd_drive: assert property (rw_read |=> s_drive_begins)
    else $error("read strobe did not drive bus");
  a_wr_strobe: assert property (rw_write |=> byte_valid_o ##1 !byte_valid_o)
    else $error("write strobe did not write one byte");
  a_e_write: assert property (e_write |=> byte_valid_o && !read_req_o)
    else $error("enable rise did not start write");

  // A frame cut by chip select must not leave bits behind for the next one
  a_ser_cs_clear: assert property (cs_n_i |=> bit_cnt == dhi_pkg::BIT_FIRST)
    else $error("bit count kept with chip select high");
  a_strap_freeze: assert property (reset_n_in_i |=> $stable(strap_q))
    else $error("straps moved outside pin reset");
  a_rd_release: assert property (mode_rw && cs_act && en_rd_i |=> data_oe_n_o == 8'hFF)
    else $error("bus driven with read strobe high");
endmodule

`default_nettype wire

/* dhi_host_model.sv */
// Purpose: Host model driving the front end pins in every protocol style.
// Assumes: Pins change 1 ns after the rising clock edge.
// Notes  : On reads the host lets go of the bus and shows inverted data.
`timescale 1ns/1ps
`default_nettype none
module dhi_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] data_oe_n_i,
  input  wire logic [7:0] dev_data_i,
  output logic      [7:0] bus_o,
  output logic            rst_n_o,
  output logic            cs_n_o,
  output logic            dc_o,
  output logic            rw_o,
  output logic            en_o,
  output logic      [2:0] strap_o
);
  logic [7:0] hd = 8'hFF;
  assign bus_o = (data_oe_n_i == 8'h00) ? dev_data_i : hd;
  initial {rst_n_o, cs_n_o, dc_o, rw_o, en_o, strap_o} = 8'hF8;
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  // Straps only move while the reset pin is low
  task automatic setup(input logic [2:0] s);
    rst_n_o = 1'b0;
    strap_o = s;
    repeat (3) tick();
    rst_n_o = 1'b1;
    tick();
  endtask
  task automatic par(input logic sep, rd, dc, cs, input logic [7:0] b);
    cs_n_o = cs;
    dc_o = dc;
    hd = rd ? ~hd : b;
    rw_o = sep | rd;
    en_o = sep;
    tick();
    if (sep && rd) en_o = 1'b0;
    else if (sep) rw_o = 1'b0;
    else en_o = 1'b1;
    repeat (2) tick();
    rw_o = sep | rd;
    en_o = sep;
    repeat (2) tick();
    cs_n_o = 1'b1;
    // Let an edge pass so the next call never reselects in this step
    tick();
  endtask
  // Sends the n leading bits, MSB first; clock rests low between frames
  task automatic ser(input logic dc, input int n, input logic [7:0] b);
    cs_n_o = 1'b0;
    dc_o = dc;
    for (int i = 7; i > 7 - n; i--) begin
      hd[0] = 1'b0;
      hd[1] = b[i];
      tick();
      hd[0] = 1'b1;
      tick();
    end
    hd[0] = 1'b0;
    hd[1] = ~hd[1];
    hd[2] = hd[1];
    tick();
    cs_n_o = 1'b1;
    tick();
  endtask
endmodule
`default_nettype wire

/* display_host_interface_front_end_tb_top.sv */
// Purpose: Self-checking bench for the display host front end.
// Assumes: Host model drives all pins; seed fixed for repeatable runs.
// Notes  : Bytes are collected by a monitor and compared per transfer.
`timescale 1ns/1ps
`default_nettype none
module display_host_interface_front_end_tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] rd_data_i = 8'h00, data_o, data_oe_n_o, byte_o, bus, b, exp_rd;
  logic read_req_o, byte_valid_o, byte_is_data_o, addr_low_bit_o, chip_init_o;
  logic rst_n, cs_n, dc, rw, en, prev_rst = 1'b1;
  logic [2:0] strap;
  logic [1:0] mode_o;
  logic [31:0] r;
  logic [8:0] got[$];
  logic [2:0] straps[4] = '{3'h4, 3'h6, 3'h0, 3'h2};
  int mismatches = 0, samples_checked = 0, cycles = 0, n;
  int seed = 32'h401a;
  always #5 clk_sys_i = ~clk_sys_i;
  dhi_host_model host (.clk_sys_i(clk_sys_i), .data_oe_n_i(data_oe_n_o),
    .dev_data_i(data_o), .bus_o(bus), .rst_n_o(rst_n), .cs_n_o(cs_n),
    .dc_o(dc), .rw_o(rw), .en_o(en), .strap_o(strap));
  dhi_front_end dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_n_in_i(rst_n),
    .cs_n_i(cs_n), .dc_sel_i(dc), .rw_sel_i(rw), .en_rd_i(en),
    .proto_strap_0_i(strap[0]), .proto_strap_1_i(strap[1]), .proto_strap_2_i(strap[2]),
    .data_i(bus), .data_o(data_o), .data_oe_n_o(data_oe_n_o), .rd_data_i(rd_data_i),
    .read_req_o(read_req_o), .byte_o(byte_o), .byte_valid_o(byte_valid_o),
    .byte_is_data_o(byte_is_data_o), .addr_low_bit_o(addr_low_bit_o),
    .chip_init_o(chip_init_o), .mode_o(mode_o));
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [8:0] exp_mode(input logic [2:0] s);
    case (s)
      3'h4: return 9'h000;
      3'h6: return 9'h001;
      3'h2: return 9'h003;
      default: return 9'h002;
    endcase
  endfunction
  // ----------------------------------------------------------------------
  // Monitor: bytes, read starts, init level and the hang limit
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles > 22) chk(9'(chip_init_o), 9'(!prev_rst));
    prev_rst <= rst_n;
    if (byte_valid_o === 1'b1) got.push_back({byte_is_data_o, byte_o});
    if (read_req_o === 1'b1) begin
      chk(9'(data_o), 9'(exp_rd));
      chk(9'(data_oe_n_o), 9'h000);
    end
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 reset_i = 1'b0;
    for (int m = 0; m < 4; m++) begin
      host.setup(straps[m]);
      chk(9'(mode_o), exp_mode(straps[m]));
      for (int k = 0; k < 14; k++) begin
        r = $random(seed);
        rd_data_i = r[7:0];
        exp_rd = r[7:0];
        b = r[15:8];
        r[17] = r[17] & (m < 2) & (k > 1);
        if (m < 2) host.par(m[0], r[17], r[16], k == 0, b);
        else host.ser(r[16], (m == 3) ? 0 : ((k == 0) ? 3 : 8), b);
        n = (m < 3) && (k > 0) && !r[17];
        if (m == 3) chk(9'(addr_low_bit_o), 9'(r[16]));
        chk(9'(got.size()), 9'(n));
        if (n == 1 && got.size() > 0) chk(got.pop_front(), {r[16], b});
        got.delete();
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
